// ---- logic/cwd_consts.svh ----
// Purpose: constants for the countdown watchdog timer
// Assumes: byte addresses on a 12-bit register port, 32-bit data
// Notes: all offsets, fields, resets and counts live here
// What this block does
// - start task loads counter from reload value
// - decrement per tick, expiry on wrap
// - keep rc oscillator on while running, unless another lf source is on
// - key in all enabled requests reloads counter
// - each request register has enable bit
// - counts during sleep and halt by default
// - optional pause during sleep or halt
// - expiry always requests system reset
// - interrupt enabled delays reset two ticks
// - pending reset can never be cancelled
// - configuration writes ignored once started
// - reset, or wake while still counting, unlocks configuration
`ifndef CWD_CONSTS_SVH
`define CWD_CONSTS_SVH
`define CWD_OFS_START 12'h000
`define CWD_OFS_STATUS 12'h100
`define CWD_OFS_MASK_SET 12'h304
`define CWD_OFS_MASK_CLR 12'h308
`define CWD_OFS_RUN 12'h400
`define CWD_OFS_REQ 12'h404
`define CWD_OFS_RELOAD_VALUE 12'h504
`define CWD_OFS_REQ_ENABLE 12'h508
`define CWD_OFS_CONFIG 12'h50c
`define CWD_OFS_REQ_BASE 12'h600
`define CWD_REQ_BASE_HI 7'h30
`define CWD_BIT_TIMEOUT 0
`define CWD_BIT_RELOADED 1
`define CWD_BIT_SLEEP_RUN 0
`define CWD_BIT_HALT_RUN 3
`define CWD_RELOAD_VALUE_RESET 32'hffffffff
`define CWD_REQ_ENABLE_RESET 8'h01
`define CWD_CONFIG_SLEEP_RESET 1'h1
`define CWD_CONFIG_HALT_RESET 1'h1
`define CWD_RELOAD_KEY 32'h6e524635
`define CWD_RESET_DELAY_TICKS 2'h2
`endif

// ---- logic/cwd_pkg.sv ----
// Purpose: types shared by the watchdog modules
// Assumes: constants come from cwd_consts.svh
// Notes: every module keeps its whole state in one struct
package cwd_pkg;
  typedef enum logic [1:0] {st_idle, st_count, st_delay, st_reset} cwd_state_t;

  typedef struct packed {
    cwd_state_t state;
    logic [31:0] counter;
    logic [31:0] reload_value;
    logic [7:0] req_enable;
    logic sleep_run;
    logic halt_run;
    logic [1:0] mask;
    logic [1:0] status;
    logic [1:0] delay_cnt;
    logic [31:0] rdata;
  } cwd_main_t;

  typedef struct packed {
    logic [7:0] pending;
    logic reload;
  } cwd_gate_t;

  typedef struct packed {
    logic prev;
  } cwd_tick_t;
endpackage

// ---- logic/cwd_tick_detect.sv ----
// Purpose: one-cycle tick on each rising edge of the low-frequency clock
// Assumes: low_freq_clock is synchronous to mclk
// Notes: tick is combinational from the input and one flop
`timescale 1ns/10ps
module cwd_tick_detect (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic low_freq_clock,
  output logic tick
);
  cwd_pkg::cwd_tick_t cur;
  cwd_pkg::cwd_tick_t next_cur;

  // remember the last level
  always_comb begin
    next_cur = cur;
    next_cur.prev = low_freq_clock;
  end

  // prev resets high so a high level at release is no edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '{prev: 1'b1};
    end else begin
      cur <= next_cur;
    end
  end

  assign tick = low_freq_clock & ~cur.prev;

  a_tick_single: assert property (@(posedge mclk) disable iff (!rst_n)
    tick |=> !tick) else $error("tick lasted more than one cycle");
endmodule

// ---- logic/cwd_reload_gate.sv ----
// Purpose: eight reload request registers and the key check
// Assumes: enable is stable while armed, locked by the caller
// Notes: reload is a registered one-cycle pulse
`timescale 1ns/10ps
`include "cwd_consts.svh"
module cwd_reload_gate (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic arm,
  input wire logic [7:0] enable,
  input wire logic req_wr,
  input wire logic [2:0] req_idx,
  input wire logic [31:0] req_data,
  output logic [7:0] pending,
  output logic reload
);
  cwd_pkg::cwd_gate_t cur;
  cwd_pkg::cwd_gate_t next_cur;
  logic [7:0] remain;

  function automatic logic key_ok(input logic [31:0] d);
    return d == `CWD_RELOAD_KEY;
  endfunction

  // only a key into an enabled register clears its pending bit
  always_comb begin
    next_cur = cur;
    next_cur.reload = 1'b0;
    remain = cur.pending & ~(8'h01 << req_idx);
    if (arm) begin
      next_cur.pending = enable;
    end else if (req_wr && key_ok(req_data) && enable[req_idx]) begin
      if (remain == 8'h00) begin
        next_cur.reload = 1'b1;
        next_cur.pending = enable;
      end else begin
        next_cur.pending = remain;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '{pending: 8'h00, reload: 1'b0};
    end else begin
      cur <= next_cur;
    end
  end

  assign pending = cur.pending;
  assign reload = cur.reload;

  a_bad_key: assert property (@(posedge mclk) disable iff (!rst_n)
    !arm && req_wr && req_data != `CWD_RELOAD_KEY |=> $stable(pending) && !reload)
    else $error("wrong key changed the requests");
  a_disabled_req: assert property (@(posedge mclk) disable iff (!rst_n)
    !arm && req_wr && !enable[req_idx] |=> $stable(pending) && !reload)
    else $error("disabled register took a request");
  a_all_keys: assert property (@(posedge mclk) disable iff (!rst_n)
    !arm && req_wr && req_data == `CWD_RELOAD_KEY && enable[req_idx]
    && (pending & ~(8'h01 << req_idx)) == 8'h00 |=> reload && pending == enable)
    else $error("last key did not reload");
endmodule

// ---- logic/cwd_watchdog.sv ----
// Purpose: countdown watchdog with locked config and reload keys
// Assumes: plain register port, read data one cycle after the strobe
// Notes: low_freq_clock edges are the count ticks
//
// The address map and the address-and-strobe port were decided locally.
`timescale 1ns/10ps
`include "cwd_consts.svh"
module cwd_watchdog (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic low_freq_clock,
  input wire logic cpu_sleeping,
  input wire logic cpu_halted,
  input wire logic other_lf_source_on,
  input wire logic wake_from_off,
  output logic rc_osc_request,
  output logic reset_request,
  output logic irq
);
  cwd_pkg::cwd_main_t cur;
  cwd_pkg::cwd_main_t next_cur;
  logic tick;
  logic count_ok;
  logic running;
  logic start_go;
  logic req_wr;
  logic cfg_open;
  logic [7:0] pending;
  logic reload;
  logic [1:0] set_bits;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
    return a == ofs;
  endfunction

  function automatic logic is_req(input logic [11:0] a);
    return a[11:5] == `CWD_REQ_BASE_HI && a[1:0] == 2'h0;
  endfunction

  cwd_tick_detect u_tick (
    .mclk(mclk),
    .rst_n(rst_n),
    .low_freq_clock(low_freq_clock),
    .tick(tick)
  );

  cwd_reload_gate u_gate (
    .mclk(mclk),
    .rst_n(rst_n),
    .arm(start_go),
    .enable(cur.req_enable),
    .req_wr(req_wr),
    .req_idx(reg_addr[4:2]),
    .req_data(reg_wdata),
    .pending(pending),
    .reload(reload)
  );

  // decoded strobes and conditions
  assign running = cur.state != cwd_pkg::st_idle;
  assign cfg_open = !running;
  assign start_go = reg_wr && hit(reg_addr, `CWD_OFS_START) && reg_wdata[0] && !running;
  assign req_wr = reg_wr && is_req(reg_addr) && cur.state == cwd_pkg::st_count;
  // pause only when the matching option is cleared
  assign count_ok = tick && (cur.sleep_run || !cpu_sleeping)
    && (cur.halt_run || !cpu_halted);

  // main next-state logic
  always_comb begin
    next_cur = cur;
    set_bits = 2'h0;
    unique case (cur.state)
      cwd_pkg::st_idle: begin
        if (start_go) begin
          next_cur.counter = cur.reload_value;
          next_cur.state = cwd_pkg::st_count;
        end
      end
      cwd_pkg::st_count: begin
        if (wake_from_off) begin
          next_cur.state = cwd_pkg::st_idle;
        end else if (count_ok && cur.counter == 32'h0) begin
          // wrap after zero: reload value plus one ticks in all
          next_cur.counter = cur.counter - 32'h1;
          set_bits[`CWD_BIT_TIMEOUT] = 1'b1;
          if (cur.mask[`CWD_BIT_TIMEOUT]) begin
            next_cur.delay_cnt = `CWD_RESET_DELAY_TICKS;
            next_cur.state = cwd_pkg::st_delay;
          end else begin
            next_cur.state = cwd_pkg::st_reset;
          end
        end else if (reload) begin
          next_cur.counter = cur.reload_value;
          set_bits[`CWD_BIT_RELOADED] = 1'b1;
        end else if (count_ok) begin
          next_cur.counter = cur.counter - 32'h1;
        end
      end
      cwd_pkg::st_delay: begin
        // raw ticks: pausing must not hold off a pending reset
        if (tick) begin
          next_cur.delay_cnt = cur.delay_cnt - 2'h1;
          if (cur.delay_cnt == 2'h1) begin
            next_cur.state = cwd_pkg::st_reset;
          end
        end
      end
      cwd_pkg::st_reset: begin
        next_cur.state = cwd_pkg::st_reset;
      end
    endcase

    // configuration writes, accepted only while stopped
    if (reg_wr && cfg_open) begin
      if (hit(reg_addr, `CWD_OFS_RELOAD_VALUE)) begin
        next_cur.reload_value = reg_wdata;
      end
      if (hit(reg_addr, `CWD_OFS_REQ_ENABLE)) begin
        next_cur.req_enable = reg_wdata[7:0];
      end
      if (hit(reg_addr, `CWD_OFS_CONFIG)) begin
        next_cur.sleep_run = reg_wdata[`CWD_BIT_SLEEP_RUN];
        next_cur.halt_run = reg_wdata[`CWD_BIT_HALT_RUN];
      end
    end

    // interrupt mask set and clear, never locked
    if (reg_wr && hit(reg_addr, `CWD_OFS_MASK_SET)) begin
      next_cur.mask = cur.mask | reg_wdata[1:0];
    end
    if (reg_wr && hit(reg_addr, `CWD_OFS_MASK_CLR)) begin
      next_cur.mask = cur.mask & ~reg_wdata[1:0];
    end

    // read clears status, a new event in the same cycle wins
    if (reg_rd && hit(reg_addr, `CWD_OFS_STATUS)) begin
      next_cur.status = set_bits;
    end else begin
      next_cur.status = cur.status | set_bits;
    end

    // read data live for the one cycle after the strobe
    next_cur.rdata = 32'h0;
    if (reg_rd) begin
      unique case (reg_addr)
        `CWD_OFS_STATUS: next_cur.rdata = {30'h0, cur.status};
        `CWD_OFS_MASK_SET: next_cur.rdata = {30'h0, cur.mask};
        `CWD_OFS_MASK_CLR: next_cur.rdata = {30'h0, cur.mask};
        `CWD_OFS_RUN: next_cur.rdata = {31'h0, running};
        `CWD_OFS_REQ: next_cur.rdata = {24'h0, pending};
        `CWD_OFS_RELOAD_VALUE: next_cur.rdata = cur.reload_value;
        `CWD_OFS_REQ_ENABLE: next_cur.rdata = {24'h0, cur.req_enable};
        `CWD_OFS_CONFIG: next_cur.rdata = {28'h0, cur.halt_run, 2'h0, cur.sleep_run};
        default: next_cur.rdata = 32'h0;
      endcase
    end
  end

  // reset returns everything to stopped and unlocked
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cur <= '{state: cwd_pkg::st_idle, counter: 32'h0,
        reload_value: `CWD_RELOAD_VALUE_RESET, req_enable: `CWD_REQ_ENABLE_RESET,
        sleep_run: `CWD_CONFIG_SLEEP_RESET, halt_run: `CWD_CONFIG_HALT_RESET,
        mask: 2'h0, status: 2'h0, delay_cnt: 2'h0, rdata: 32'h0};
    end else begin
      cur <= next_cur;
    end
  end

  // outputs
  assign reg_rdata = cur.rdata;
  assign rc_osc_request = running && !other_lf_source_on;
  assign reset_request = cur.state == cwd_pkg::st_reset;
  assign irq = |(cur.status & cur.mask);

  a_start_load: assert property (@(posedge mclk) disable iff (!rst_n)
    start_go |=> cur.state == cwd_pkg::st_count && cur.counter == $past(cur.reload_value))
    else $error("start did not load the counter");
  a_count_step: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state == cwd_pkg::st_count && count_ok && !reload && !wake_from_off
    |=> cur.counter == $past(cur.counter) - 32'h1)
    else $error("counter did not step once per tick");
  a_default_run: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state == cwd_pkg::st_count && tick && cur.sleep_run && cur.halt_run
    && !reload && !wake_from_off |=> cur.counter != $past(cur.counter))
    else $error("counter paused without option");
  a_pause_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state == cwd_pkg::st_count && !reload
    && ((cpu_sleeping && !cur.sleep_run) || (cpu_halted && !cur.halt_run))
    |=> $stable(cur.counter))
    else $error("counter moved while paused");
  a_expiry_event: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state == cwd_pkg::st_count && count_ok && cur.counter == 32'h0 && !wake_from_off
    |=> cur.status[`CWD_BIT_TIMEOUT] && cur.counter == 32'hffffffff)
    else $error("wrap raised no expiry");
  a_reset_now: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state == cwd_pkg::st_count && count_ok && cur.counter == 32'h0
    && !wake_from_off && !cur.mask[`CWD_BIT_TIMEOUT] |=> reset_request)
    else $error("expiry gave no reset");
  a_reset_delay: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state == cwd_pkg::st_count && count_ok && cur.counter == 32'h0
    && !wake_from_off && cur.mask[`CWD_BIT_TIMEOUT]
    |=> !reset_request && cur.delay_cnt == 2'h2)
    else $error("interrupt did not delay reset");
  a_delay_end: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state == cwd_pkg::st_delay && tick && cur.delay_cnt == 2'h1 |=> reset_request)
    else $error("reset not raised after two ticks");
  a_reset_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    reset_request |=> reset_request)
    else $error("pending reset was cancelled");
  a_delay_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state == cwd_pkg::st_delay |=> cur.state inside {cwd_pkg::st_delay, cwd_pkg::st_reset})
    else $error("delayed reset was cancelled");
  a_rc_keep: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(running) && !other_lf_source_on |-> rc_osc_request)
    else $error("oscillator not requested");
  a_cfg_lock: assert property (@(posedge mclk) disable iff (!rst_n)
    running && reg_wr |=> $stable(cur.reload_value) && $stable(cur.req_enable)
    && $stable(cur.sleep_run) && $stable(cur.halt_run))
    else $error("locked configuration changed");
  a_cfg_open: assert property (@(posedge mclk) disable iff (!rst_n)
    !running && reg_wr && reg_addr == `CWD_OFS_RELOAD_VALUE
    |=> cur.reload_value == $past(reg_wdata))
    else $error("unlocked write was lost");
  a_reload_load: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state == cwd_pkg::st_count && reload && !wake_from_off
    && !(count_ok && cur.counter == 32'h0) |=> cur.counter == $past(cur.reload_value))
    else $error("reload did not load the counter");

  // counter moves only on start, a tick or a reload, never wraps early
  a_idle_hold: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state == cwd_pkg::st_idle && !start_go |=> $stable(cur.counter))
    else $error("counter moved while stopped");
  a_tick_only: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state == cwd_pkg::st_count && !tick && !reload |=> $stable(cur.counter))
    else $error("counter moved without a tick");
  a_no_early_exp: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state == cwd_pkg::st_count && count_ok && cur.counter != 32'h0 && !wake_from_off
    |=> cur.state == cwd_pkg::st_count)
    else $error("expiry before the count ran out");
  a_pending_arm: assert property (@(posedge mclk) disable iff (!rst_n)
    start_go |=> pending == $past(cur.req_enable))
    else $error("start did not arm the enabled requests");
  a_delay_wait: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state == cwd_pkg::st_delay && !tick
    |=> cur.state == cwd_pkg::st_delay && $stable(cur.delay_cnt))
    else $error("reset delay moved without a tick");
  a_delay_reload: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state inside {cwd_pkg::st_delay, cwd_pkg::st_reset} && reload
    |=> $stable(cur.counter))
    else $error("reload acted after expiry");
  a_req_idle: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state != cwd_pkg::st_count && reg_wr && is_req(reg_addr) |=> !reload)
    else $error("request outside counting gave a reload");
  a_wake_stop: assert property (@(posedge mclk) disable iff (!rst_n)
    cur.state == cwd_pkg::st_count && wake_from_off |=> !running)
    else $error("wake did not stop and unlock");
endmodule

// ---- dv/cwd_watchdog_tb_top.sv ----
// Purpose: self-checking bench for the countdown watchdog timer
// Assumes: register port with read data one cycle after the strobe
// Notes: low-frequency ticks are made by hand, so counts stay short
`timescale 1ns/10ps
`include "cwd_consts.svh"
module cwd_watchdog_tb_top;
  logic mclk;
  logic rst_n;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic low_freq_clock;
  logic cpu_sleeping;
  logic cpu_halted;
  logic other_lf_source_on;
  logic wake_from_off;
  logic rc_osc_request;
  logic reset_request;
  logic irq;
  int bad_count;
  int checked;
  logic [31:0] key;

  cwd_watchdog cwd_watchdog_i (
    .mclk(mclk),
    .rst_n(rst_n),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .low_freq_clock(low_freq_clock),
    .cpu_sleeping(cpu_sleeping),
    .cpu_halted(cpu_halted),
    .other_lf_source_on(other_lf_source_on),
    .wake_from_off(wake_from_off),
    .rc_osc_request(rc_osc_request),
    .reset_request(reset_request),
    .irq(irq)
  );

  // 200 MHz system clock
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  // verdict and end of run, shared by the main sequence and the hang guard
  task automatic end_of_test();
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      $display("mismatch %s expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  // one-cycle write strobe
  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe edge
  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    chk(name, exp, reg_rdata);
  endtask

  // each tick is a rising edge, kept well apart from the next one
  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge mclk);
      low_freq_clock <= 1'b1;
      repeat (2) @(posedge mclk);
      low_freq_clock <= 1'b0;
      repeat (2) @(posedge mclk);
    end
    #1;
  endtask

  task automatic do_reset();
    @(posedge mclk);
    rst_n <= 1'b0;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
  endtask

  // hang guard: a run far beyond the sequence length counts as a failure
  initial begin
    repeat (100000) @(posedge mclk);
    bad_count++;
    end_of_test();
  end

  initial begin
    rst_n = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h00000000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    low_freq_clock = 1'b0;
    cpu_sleeping = 1'b0;
    cpu_halted = 1'b0;
    other_lf_source_on = 1'b0;
    wake_from_off = 1'b0;
    bad_count = 0;
    checked = 0;
    key = `CWD_RELOAD_KEY;
    repeat (16) @(posedge mclk);
    rst_n <= 1'b1;
    // reset values and an unmapped place
    rd_chk("reload_value", `CWD_OFS_RELOAD_VALUE, 32'hffffffff);
    rd_chk("req_enable", `CWD_OFS_REQ_ENABLE, 32'h00000001);
    rd_chk("config", `CWD_OFS_CONFIG, 32'h00000009);
    rd_chk("running", `CWD_OFS_RUN, 32'h00000000);
    rd_chk("unmapped", 12'h7f0, 32'h00000000);
    chk("rc_osc_idle", 32'h0, 32'(rc_osc_request));
    // configure, then start with pauses on in sleep and halt
    wr_reg(`CWD_OFS_RELOAD_VALUE, 32'h00000003);
    wr_reg(`CWD_OFS_REQ_ENABLE, 32'h00000005);
    wr_reg(`CWD_OFS_CONFIG, 32'h00000000);
    wr_reg(`CWD_OFS_START, 32'h00000001);
    rd_chk("running", `CWD_OFS_RUN, 32'h00000001);
    chk("rc_osc_run", 32'h1, 32'(rc_osc_request));
    @(posedge mclk);
    other_lf_source_on <= 1'b1;
    @(posedge mclk);
    #1;
    chk("rc_osc_other", 32'h0, 32'(rc_osc_request));
    @(posedge mclk);
    other_lf_source_on <= 1'b0;
    // locked configuration drops writes
    wr_reg(`CWD_OFS_RELOAD_VALUE, 32'h00000007);
    wr_reg(`CWD_OFS_REQ_ENABLE, 32'h000000ff);
    wr_reg(`CWD_OFS_CONFIG, 32'h00000009);
    rd_chk("reload_locked", `CWD_OFS_RELOAD_VALUE, 32'h00000003);
    rd_chk("enable_locked", `CWD_OFS_REQ_ENABLE, 32'h00000005);
    rd_chk("config_locked", `CWD_OFS_CONFIG, 32'h00000000);
    rd_chk("pending", `CWD_OFS_REQ, 32'h00000005);
    // wrong key, then a key to a disabled index, then completion
    wr_reg(`CWD_OFS_REQ_BASE, key ^ 32'h00000001);
    rd_chk("pending_bad_key", `CWD_OFS_REQ, 32'h00000005);
    wr_reg(`CWD_OFS_REQ_BASE, key);
    wr_reg(`CWD_OFS_REQ_BASE + 12'h004, key);
    rd_chk("pending_part", `CWD_OFS_REQ, 32'h00000004);
    wr_reg(`CWD_OFS_REQ_BASE + 12'h008, key);
    rd_chk("pending_rearm", `CWD_OFS_REQ, 32'h00000005);
    rd_chk("status_reload", `CWD_OFS_STATUS, 32'h00000002);
    chk("irq_masked", 32'h0, 32'(irq));
    // paused in sleep and in halt: many ticks, no expiry
    @(posedge mclk);
    cpu_sleeping <= 1'b1;
    ticks(6);
    @(posedge mclk);
    cpu_sleeping <= 1'b0;
    cpu_halted <= 1'b1;
    ticks(6);
    @(posedge mclk);
    cpu_halted <= 1'b0;
    rd_chk("status_paused", `CWD_OFS_STATUS, 32'h00000000);
    // two ticks leave one, so a lost reload would expire early below
    ticks(2);
    wr_reg(`CWD_OFS_REQ_BASE, key);
    wr_reg(`CWD_OFS_REQ_BASE + 12'h008, key);
    rd_chk("status_reload2", `CWD_OFS_STATUS, 32'h00000002);
    // reload value 3 expires on the fourth counting tick
    ticks(3);
    chk("reset_early", 32'h0, 32'(reset_request));
    ticks(1);
    chk("reset_now", 32'h1, 32'(reset_request));
    rd_chk("status_timeout", `CWD_OFS_STATUS, 32'h00000001);
    wr_reg(`CWD_OFS_REQ_BASE, key);
    wr_reg(`CWD_OFS_REQ_BASE + 12'h008, key);
    ticks(2);
    chk("reset_kept", 32'h1, 32'(reset_request));
    do_reset();
    chk("reset_cleared", 32'h0, 32'(reset_request));
    rd_chk("reload_unlock", `CWD_OFS_RELOAD_VALUE, 32'hffffffff);
    // interrupt enabled: reset waits two ticks, counting goes on in sleep and halt
    wr_reg(`CWD_OFS_RELOAD_VALUE, 32'h00000001);
    wr_reg(`CWD_OFS_MASK_SET, 32'h00000001);
    rd_chk("mask_set", `CWD_OFS_MASK_SET, 32'h00000001);
    wr_reg(`CWD_OFS_START, 32'h00000001);
    cpu_sleeping <= 1'b1;
    cpu_halted <= 1'b1;
    ticks(1);
    chk("irq_early", 32'h0, 32'(irq));
    ticks(1);
    chk("irq_expiry", 32'h1, 32'(irq));
    chk("reset_delay0", 32'h0, 32'(reset_request));
    ticks(1);
    chk("reset_delay1", 32'h0, 32'(reset_request));
    ticks(1);
    chk("reset_delay2", 32'h1, 32'(reset_request));
    rd_chk("status_irq", `CWD_OFS_STATUS, 32'h00000001);
    chk("irq_cleared", 32'h0, 32'(irq));
    wr_reg(`CWD_OFS_MASK_CLR, 32'h00000001);
    rd_chk("mask_clr", `CWD_OFS_MASK_CLR, 32'h00000000);
    // wake from off stops the counter and reopens configuration
    do_reset();
    cpu_sleeping <= 1'b0;
    cpu_halted <= 1'b0;
    wr_reg(`CWD_OFS_START, 32'h00000001);
    rd_chk("running_wake", `CWD_OFS_RUN, 32'h00000001);
    @(posedge mclk);
    wake_from_off <= 1'b1;
    @(posedge mclk);
    wake_from_off <= 1'b0;
    rd_chk("stopped_wake", `CWD_OFS_RUN, 32'h00000000);
    wr_reg(`CWD_OFS_RELOAD_VALUE, 32'h00000005);
    rd_chk("reload_wake", `CWD_OFS_RELOAD_VALUE, 32'h00000005);
    end_of_test();
  end
endmodule
